// ---- alod_pkg.sv ----
// Package for the arithmetic/logic opcode decoder.
// Assumes one system clock; shared by decoder and its testbench.
`default_nettype none
package alod_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SYS_CLK_PER_MCYCLE = 2;

  // Opcode bases for each group
  localparam logic [7:0] OP_ADD_DIR = 8'h25;
  localparam logic [7:0] OP_ADD_IND = 8'h26;
  localparam logic [7:0] OP_ADD_WITH_CARRY_IMM = 8'h34;
  localparam logic [7:0] OP_ADD_WITH_CARRY_DIR = 8'h35;
  localparam logic [7:0] OP_ADD_WITH_CARRY_IND = 8'h36;
  localparam logic [7:0] OP_ADD_WITH_CARRY_REG = 8'h38;
  localparam logic [7:0] OP_ORL_DIR_IMM = 8'h43;
  localparam logic [7:0] OP_ORL_IND = 8'h46;
  localparam logic [7:0] OP_ANL_DIR_A = 8'h52;
  localparam logic [7:0] OP_ANL_DIR_IMM = 8'h53;
  localparam logic [7:0] OP_ANL_DIR = 8'h55;
  localparam logic [7:0] OP_ANL_IND = 8'h56;
  localparam logic [7:0] OP_XRL_DIR = 8'h65;
  localparam logic [7:0] OP_XRL_IND = 8'h66;
  localparam logic [7:0] OP_XRL_REG = 8'h68;
  localparam logic [7:0] OP_SUBTRACT_WITH_BORROW_IMM = 8'h94;
  localparam logic [7:0] OP_SUBTRACT_WITH_BORROW_DIR = 8'h95;
  localparam logic [7:0] OP_SUBTRACT_WITH_BORROW_IND = 8'h96;
  localparam logic [7:0] OP_SUBTRACT_WITH_BORROW_REG = 8'h98;

  localparam logic [7:0] REG_GROUP_MASK = 8'hf8;
  localparam logic [7:0] IND_GROUP_MASK = 8'hfe;

  typedef enum logic [2:0] {
    ALOD_OP_NONE = 3'h0,
    ALOD_OP_ADD = 3'h1,
    ALOD_OP_ADD_WITH_CARRY = 3'h2,
    ALOD_OP_SUBTRACT_WITH_BORROW = 3'h3,
    ALOD_OP_BITWISE_AND = 3'h4,
    ALOD_OP_BITWISE_OR = 3'h5,
    ALOD_OP_BITWISE_XOR = 3'h6
  } alod_op_t;

  typedef enum logic [2:0] {
    ALOD_SRC_NONE = 3'h0,
    ALOD_SRC_WORKING_REGISTER = 3'h1,
    ALOD_SRC_DIRECT = 3'h2,
    ALOD_SRC_INDIRECT = 3'h3,
    ALOD_SRC_IMMEDIATE = 3'h4
  } alod_src_t;

  typedef enum logic [1:0] {
    ALOD_DST_ACC = 2'h0,
    ALOD_DST_DIRECT = 2'h1
  } alod_dst_t;

  typedef struct packed {
    logic valid;
    alod_op_t op;
    alod_src_t src;
    alod_dst_t dst;
    logic [2:0] reg_sel;
    logic ptr_sel;
    logic [1:0] length;
    logic [2:0] mcycles;
    logic [7:0] operand1;
    logic [7:0] operand2;
  } alod_uop_t;

  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [2:0] MC_ONE = 3'h1;
  localparam logic [2:0] MC_TWO = 3'h2;
  localparam logic [2:0] MC_FOUR = 3'h4;

endpackage

`default_nettype wire

// ---- alod_decoder.sv ----
// Arithmetic and logical opcode decoder with operand fetch and timing.
// Assumes fetch logic offers code bytes with valid/ready on clk_sys and
// the execute datapath accepts one micro-op per handshake.
// Overview of operation
// - Machine cycle equals two system clocks
// - Fetch one to three bytes per length
// - Execute in one or two cycles
// - 38-3F add register with carry
// - 35 add direct byte with carry
// - 36-37 add indirect byte with carry
// - 34 add immediate with carry
// - 25 add direct byte, no carry
// - 26-27 add indirect byte, no carry
// - 98-9F subtract register with borrow
// - 95 subtract direct byte with borrow
// - 96-97 subtract indirect byte with borrow
// - 94 subtract immediate with borrow
// - 55, 56-57 AND into accumulator
// - 52 AND accumulator into direct byte
// - 53 AND immediate into direct byte
// - 43 OR immediate into direct byte
// - 46-47 OR indirect byte into accumulator
// - 68-6F XOR register into accumulator
// - 65 XOR direct byte into accumulator
// - 66-67 XOR indirect byte into accumulator
`timescale 1ns/1ps
`default_nettype none

module alod_decoder (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic code_valid,
  input wire logic [7:0] code_byte,
  output logic code_ready,
  output alod_pkg::alod_uop_t uop,
  output logic uop_valid,
  input wire logic uop_ready,
  output logic unknown_opcode,
  output logic busy
);

  typedef enum logic [4:0] {
    ALOD_ST_OPCODE = 5'b00001,
    ALOD_ST_OPND1 = 5'b00010,
    ALOD_ST_OPND2 = 5'b00100,
    ALOD_ST_ISSUE = 5'b01000,
    ALOD_ST_EXEC = 5'b10000
  } alod_state_t;

  alod_state_t state_reg;
  alod_state_t state_next;
  alod_pkg::alod_uop_t dec;
  alod_pkg::alod_uop_t uop_reg;
  logic unknown_reg;
  logic [2:0] mc_left_reg;
  logic phase_reg;
  logic mcycle_tick;
  logic [7:0] opc;
  logic take_byte;

  assign opc = code_byte;
  assign take_byte = code_valid && code_ready;

  // Combinational table lookup of the opcode
  always_comb begin
    dec = '0;
    dec.valid = 1'b1;
    dec.reg_sel = opc[2:0];
    dec.ptr_sel = opc[0];
    dec.dst = alod_pkg::ALOD_DST_ACC;
    dec.length = alod_pkg::LEN_ONE;
    dec.mcycles = alod_pkg::MC_ONE;
    if ((opc & alod_pkg::REG_GROUP_MASK) == alod_pkg::OP_ADD_WITH_CARRY_REG) begin
      dec.op = alod_pkg::ALOD_OP_ADD_WITH_CARRY;
      dec.src = alod_pkg::ALOD_SRC_WORKING_REGISTER;
    end else if ((opc & alod_pkg::REG_GROUP_MASK) ==
                 alod_pkg::OP_SUBTRACT_WITH_BORROW_REG) begin
      dec.op = alod_pkg::ALOD_OP_SUBTRACT_WITH_BORROW;
      dec.src = alod_pkg::ALOD_SRC_WORKING_REGISTER;
    end else if ((opc & alod_pkg::REG_GROUP_MASK) ==
                 alod_pkg::OP_XRL_REG) begin
      dec.op = alod_pkg::ALOD_OP_BITWISE_XOR;
      dec.src = alod_pkg::ALOD_SRC_WORKING_REGISTER;
    end else if ((opc & alod_pkg::IND_GROUP_MASK) ==
                 alod_pkg::OP_ADD_WITH_CARRY_IND) begin
      dec.op = alod_pkg::ALOD_OP_ADD_WITH_CARRY;
      dec.src = alod_pkg::ALOD_SRC_INDIRECT;
    end else if ((opc & alod_pkg::IND_GROUP_MASK) ==
                 alod_pkg::OP_ADD_IND) begin
      dec.op = alod_pkg::ALOD_OP_ADD;
      dec.src = alod_pkg::ALOD_SRC_INDIRECT;
    end else if ((opc & alod_pkg::IND_GROUP_MASK) ==
                 alod_pkg::OP_SUBTRACT_WITH_BORROW_IND) begin
      dec.op = alod_pkg::ALOD_OP_SUBTRACT_WITH_BORROW;
      dec.src = alod_pkg::ALOD_SRC_INDIRECT;
    end else if ((opc & alod_pkg::IND_GROUP_MASK) ==
                 alod_pkg::OP_ANL_IND) begin
      dec.op = alod_pkg::ALOD_OP_BITWISE_AND;
      dec.src = alod_pkg::ALOD_SRC_INDIRECT;
    end else if ((opc & alod_pkg::IND_GROUP_MASK) ==
                 alod_pkg::OP_ORL_IND) begin
      dec.op = alod_pkg::ALOD_OP_BITWISE_OR;
      dec.src = alod_pkg::ALOD_SRC_INDIRECT;
    end else if ((opc & alod_pkg::IND_GROUP_MASK) ==
                 alod_pkg::OP_XRL_IND) begin
      dec.op = alod_pkg::ALOD_OP_BITWISE_XOR;
      dec.src = alod_pkg::ALOD_SRC_INDIRECT;
    end else begin
      dec.length = alod_pkg::LEN_TWO;
      dec.src = alod_pkg::ALOD_SRC_DIRECT;
      case (opc)
        alod_pkg::OP_ADD_WITH_CARRY_DIR: begin
          dec.op = alod_pkg::ALOD_OP_ADD_WITH_CARRY;
        end
        alod_pkg::OP_ADD_WITH_CARRY_IMM: begin
          dec.op = alod_pkg::ALOD_OP_ADD_WITH_CARRY;
          dec.src = alod_pkg::ALOD_SRC_IMMEDIATE;
        end
        alod_pkg::OP_ADD_DIR: begin
          dec.op = alod_pkg::ALOD_OP_ADD;
        end
        alod_pkg::OP_SUBTRACT_WITH_BORROW_DIR: begin
          dec.op = alod_pkg::ALOD_OP_SUBTRACT_WITH_BORROW;
        end
        alod_pkg::OP_SUBTRACT_WITH_BORROW_IMM: begin
          dec.op = alod_pkg::ALOD_OP_SUBTRACT_WITH_BORROW;
          dec.src = alod_pkg::ALOD_SRC_IMMEDIATE;
        end
        alod_pkg::OP_ANL_DIR: begin
          dec.op = alod_pkg::ALOD_OP_BITWISE_AND;
        end
        alod_pkg::OP_ANL_DIR_A: begin
          dec.op = alod_pkg::ALOD_OP_BITWISE_AND;
          dec.dst = alod_pkg::ALOD_DST_DIRECT;
        end
        alod_pkg::OP_ANL_DIR_IMM: begin
          dec.op = alod_pkg::ALOD_OP_BITWISE_AND;
          dec.src = alod_pkg::ALOD_SRC_IMMEDIATE;
          dec.dst = alod_pkg::ALOD_DST_DIRECT;
          dec.length = alod_pkg::LEN_THREE;
          dec.mcycles = alod_pkg::MC_TWO;
        end
        alod_pkg::OP_ORL_DIR_IMM: begin
          dec.op = alod_pkg::ALOD_OP_BITWISE_OR;
          dec.src = alod_pkg::ALOD_SRC_IMMEDIATE;
          dec.dst = alod_pkg::ALOD_DST_DIRECT;
          dec.length = alod_pkg::LEN_THREE;
          dec.mcycles = alod_pkg::MC_TWO;
        end
        alod_pkg::OP_XRL_DIR: begin
          dec.op = alod_pkg::ALOD_OP_BITWISE_XOR;
        end
        default: begin
          // Outside these groups: one-byte no-op, flagged to the core
          dec.valid = 1'b0;
          dec.op = alod_pkg::ALOD_OP_NONE;
          dec.src = alod_pkg::ALOD_SRC_NONE;
          dec.length = alod_pkg::LEN_ONE;
        end
      endcase
    end
  end

  // Byte fetch and issue sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ALOD_ST_OPCODE: begin
        if (take_byte) begin
          if (dec.length == alod_pkg::LEN_ONE) begin
            state_next = ALOD_ST_ISSUE;
          end else begin
            state_next = ALOD_ST_OPND1;
          end
        end
      end
      ALOD_ST_OPND1: begin
        if (take_byte) begin
          if (uop_reg.length == alod_pkg::LEN_THREE) begin
            state_next = ALOD_ST_OPND2;
          end else begin
            state_next = ALOD_ST_ISSUE;
          end
        end
      end
      ALOD_ST_OPND2: begin
        if (take_byte) begin
          state_next = ALOD_ST_ISSUE;
        end
      end
      ALOD_ST_ISSUE: begin
        if (uop_ready) begin
          state_next = ALOD_ST_EXEC;
        end
      end
      ALOD_ST_EXEC: begin
        if (mcycle_tick && mc_left_reg == 3'h1) begin
          state_next = ALOD_ST_OPCODE;
        end
      end
      default: begin
        state_next = ALOD_ST_OPCODE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ALOD_ST_OPCODE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Captured micro-op and operand bytes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      uop_reg <= '0;
      unknown_reg <= 1'b0;
    end else if (take_byte) begin
      if (state_reg == ALOD_ST_OPCODE) begin
        uop_reg <= dec;
        unknown_reg <= !dec.valid;
      end else if (state_reg == ALOD_ST_OPND1) begin
        uop_reg.operand1 <= code_byte;
      end else begin
        uop_reg.operand2 <= code_byte;
      end
    end
  end

  // Machine-cycle phase: a tick every second system clock in execution
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= 1'b0;
    end else if (state_reg == ALOD_ST_EXEC) begin
      phase_reg <= ~phase_reg;
    end else begin
      phase_reg <= 1'b0;
    end
  end

  assign mcycle_tick = (state_reg == ALOD_ST_EXEC) && phase_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mc_left_reg <= 3'h0;
    end else if (state_reg == ALOD_ST_ISSUE && uop_ready) begin
      mc_left_reg <= uop_reg.mcycles;
    end else if (mcycle_tick) begin
      mc_left_reg <= mc_left_reg - 3'h1;
    end
  end

  assign code_ready = (state_reg == ALOD_ST_OPCODE) ||
                      (state_reg == ALOD_ST_OPND1) ||
                      (state_reg == ALOD_ST_OPND2);
  assign uop_valid = (state_reg == ALOD_ST_ISSUE);
  assign uop = uop_reg;
  assign unknown_opcode = unknown_reg;
  assign busy = (state_reg != ALOD_ST_OPCODE);

endmodule

`default_nettype wire

// ---- alod_decoder_properties.sv ----
// Port checker for the opcode decoder, bound to every instance.
// Assumes one clock and an async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module alod_decoder_chk (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic code_valid,
  input wire logic [7:0] code_byte,
  input wire logic code_ready,
  input wire alod_pkg::alod_uop_t uop,
  input wire logic uop_valid,
  input wire logic uop_ready,
  input wire logic unknown_opcode,
  input wire logic busy
);
  logic [7:0] opc_reg;
  logic [1:0] cnt_reg;
  wire logic take = code_valid && code_ready;
  wire logic hs = uop_valid && uop_ready;
  // Opcode is the byte taken while idle; later bytes are operands
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      opc_reg <= 8'h00;
      cnt_reg <= 2'h0;
    end else if (take && !busy) begin
      opc_reg <= code_byte;
      cnt_reg <= 2'h1;
    end else if (take) begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_uop_follows_byte: assert property ($rose(uop_valid) |->
    $past(take)) else $error("micro-op without a byte taken");
  a_length_matches: assert property ($rose(uop_valid) |->
    uop.length == cnt_reg) else $error("length differs from bytes taken");
  a_exec_one_mc: assert property (hs &&
    uop.mcycles == alod_pkg::MC_ONE |=> !code_ready [*2] ##1 code_ready)
    else $error("one-cycle timing");
  a_exec_two_mc: assert property (hs &&
    uop.mcycles == alod_pkg::MC_TWO |=> !code_ready [*4] ##1 code_ready)
    else $error("two-cycle timing");
  a_uop_holds: assert property (uop_valid && !uop_ready |=>
    uop_valid && $stable(uop)) else $error("micro-op dropped or changed");
  a_no_fetch_issue: assert property (uop_valid |-> !code_ready)
    else $error("byte accepted during issue");
  a_reg_ptr_sel: assert property ($rose(uop_valid) |->
    uop.reg_sel == opc_reg[2:0] && uop.ptr_sel == opc_reg[0])
    else $error("register or pointer select wrong");
  a_add_with_carry_reg: assert property ($rose(uop_valid) &&
    opc_reg[7:3] == 5'h07 |-> uop.op == alod_pkg::ALOD_OP_ADD_WITH_CARRY &&
    uop.src == alod_pkg::ALOD_SRC_WORKING_REGISTER)
    else $error("register add with carry decoded wrong");
  a_subtract_with_borrow_reg: assert property ($rose(uop_valid) &&
    opc_reg[7:3] == 5'h13 |->
    uop.op == alod_pkg::ALOD_OP_SUBTRACT_WITH_BORROW &&
    uop.length == alod_pkg::LEN_ONE) else $error("register subtract wrong");
  c_two_mc: cover property (hs && uop.mcycles == alod_pkg::MC_TWO);
  c_stall: cover property (uop_valid && !uop_ready ##1 uop_valid);
  c_unknown: cover property ($rose(unknown_opcode));
endmodule
bind alod_decoder alod_decoder_chk alod_decoder_chk_inst (
  .clk_sys(clk_sys), .arst_n(arst_n), .code_valid(code_valid),
  .code_byte(code_byte), .code_ready(code_ready), .uop(uop),
  .uop_valid(uop_valid), .uop_ready(uop_ready),
  .unknown_opcode(unknown_opcode), .busy(busy));
`default_nettype wire

// ---- alod_exec_model.sv ----
// Execute-side model: accepts each micro-op after a set stall.
// Assumes the decoder holds uop_valid until accepted.
`timescale 1ns/1ps
`default_nettype none
module alod_exec_model (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic uop_valid,
  input wire logic [3:0] stall,
  output logic uop_ready
);
  logic [3:0] wait_reg;
  // Ready only while offered, so no accept leaks onto a later uop
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wait_reg <= 4'h0;
      uop_ready <= 1'b0;
    end else begin
      wait_reg <= (uop_valid && !uop_ready) ? wait_reg + 4'h1 : 4'h0;
      uop_ready <= uop_valid && !uop_ready && wait_reg >= stall;
    end
  end
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the opcode decoder.
// Assumes the checker binds itself to the decoder.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("FAIL %0t: got %0h exp %0h", $time, g, e); end end
module tb;
  localparam alod_pkg::alod_op_t AD = alod_pkg::ALOD_OP_ADD;
  localparam alod_pkg::alod_op_t AC = alod_pkg::ALOD_OP_ADD_WITH_CARRY;
  localparam alod_pkg::alod_op_t SB = alod_pkg::ALOD_OP_SUBTRACT_WITH_BORROW;
  localparam alod_pkg::alod_op_t AN = alod_pkg::ALOD_OP_BITWISE_AND;
  localparam alod_pkg::alod_op_t OO = alod_pkg::ALOD_OP_BITWISE_OR;
  localparam alod_pkg::alod_op_t XR = alod_pkg::ALOD_OP_BITWISE_XOR;
  localparam alod_pkg::alod_op_t NO = alod_pkg::ALOD_OP_NONE;
  localparam alod_pkg::alod_src_t RG = alod_pkg::ALOD_SRC_WORKING_REGISTER;
  localparam alod_pkg::alod_src_t DI = alod_pkg::ALOD_SRC_DIRECT;
  localparam alod_pkg::alod_src_t IN = alod_pkg::ALOD_SRC_INDIRECT;
  localparam alod_pkg::alod_src_t IM = alod_pkg::ALOD_SRC_IMMEDIATE;
  localparam alod_pkg::alod_dst_t DA = alod_pkg::ALOD_DST_ACC;
  localparam alod_pkg::alod_dst_t DD = alod_pkg::ALOD_DST_DIRECT;
  logic clk_sys, arst_n, code_valid, code_ready, uop_valid, uop_ready;
  logic unknown_opcode, busy;
  logic [7:0] code_byte;
  logic [3:0] stall;
  alod_pkg::alod_uop_t uop;
  int fails = 0;
  int comparisons = 0;

  alod_decoder alod_decoder_inst (.clk_sys(clk_sys), .arst_n(arst_n),
    .code_valid(code_valid), .code_byte(code_byte), .code_ready(code_ready),
    .uop(uop), .uop_valid(uop_valid), .uop_ready(uop_ready),
    .unknown_opcode(unknown_opcode), .busy(busy));
  alod_exec_model alod_exec_model_inst (.clk_sys(clk_sys), .arst_n(arst_n),
    .uop_valid(uop_valid), .stall(stall), .uop_ready(uop_ready));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic end_sim;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Sends one instruction, then judges the micro-op and its run time
  task automatic run(input logic [7:0] b0, input alod_pkg::alod_op_t op,
      input alod_pkg::alod_src_t src, input alod_pkg::alod_dst_t dst,
      input logic [1:0] len);
    logic [7:0] b [3];
    logic [2:0] mc;
    int n;
    b = '{b0, b0 ^ 8'h5a, ~b0};
    mc = (len == alod_pkg::LEN_THREE) ? alod_pkg::MC_TWO : alod_pkg::MC_ONE;
    n = 0;
    @(posedge clk_sys);
    for (int i = 0; i < int'(len); i++) begin
      code_byte <= b[i];
      code_valid <= 1'b1;
      do @(negedge clk_sys); while (code_ready !== 1'b1);
      @(posedge clk_sys);
    end
    code_valid <= 1'b0;
    code_byte <= ~b[len - 2'h1];
    do @(negedge clk_sys); while (uop_valid !== 1'b1);
    if (op != NO) begin
      `CHK(uop.op, op)
      `CHK(uop.src, src)
      `CHK(uop.dst, dst)
    end
    `CHK(uop.valid, op != NO)
    `CHK(unknown_opcode, op == NO)
    `CHK(busy, 1'b1)
    `CHK(uop.length, len)
    `CHK(uop.mcycles, mc)
    `CHK(uop.reg_sel, b0[2:0])
    `CHK(uop.ptr_sel, b0[0])
    if (len > 2'h1) `CHK(uop.operand1, b[1])
    if (len > 2'h2) `CHK(uop.operand2, b[2])
    do @(negedge clk_sys); while (uop_valid === 1'b1);
    while (code_ready !== 1'b1) begin
      n++;
      @(negedge clk_sys);
    end
    `CHK(n, int'(mc) * int'(alod_pkg::SYS_CLK_PER_MCYCLE))
    `CHK(busy, 1'b0)
  endtask

  task automatic t_add;
    for (int i = 0; i < 8; i++) run(8'h38 + 8'(i), AC, RG, DA, 2'h1);
    run(8'h35, AC, DI, DA, 2'h2);
    run(8'h36, AC, IN, DA, 2'h1);
    run(8'h37, AC, IN, DA, 2'h1);
    run(8'h34, AC, IM, DA, 2'h2);
    run(8'h25, AD, DI, DA, 2'h2);
    run(8'h26, AD, IN, DA, 2'h1);
    run(8'h27, AD, IN, DA, 2'h1);
    $display("t_add done");
  endtask

  task automatic t_subtract_with_borrow;
    for (int i = 0; i < 8; i++) run(8'h98 + 8'(i), SB, RG, DA, 2'h1);
    run(8'h95, SB, DI, DA, 2'h2);
    run(8'h96, SB, IN, DA, 2'h1);
    run(8'h97, SB, IN, DA, 2'h1);
    run(8'h94, SB, IM, DA, 2'h2);
    $display("t_subtract_with_borrow done");
  endtask

  task automatic t_logic;
    run(8'h55, AN, DI, DA, 2'h2);
    run(8'h56, AN, IN, DA, 2'h1);
    run(8'h57, AN, IN, DA, 2'h1);
    run(8'h52, AN, DI, DD, 2'h2);
    run(8'h53, AN, IM, DD, 2'h3);
    run(8'h43, OO, IM, DD, 2'h3);
    run(8'h46, OO, IN, DA, 2'h1);
    run(8'h47, OO, IN, DA, 2'h1);
    $display("t_logic done");
  endtask

  task automatic t_xor;
    for (int i = 0; i < 8; i++) run(8'h68 + 8'(i), XR, RG, DA, 2'h1);
    run(8'h65, XR, DI, DA, 2'h2);
    run(8'h66, XR, IN, DA, 2'h1);
    run(8'h67, XR, IN, DA, 2'h1);
    $display("t_xor done");
  endtask

  // Slow execute side: micro-op must stand through the stall
  task automatic t_slow;
    @(posedge clk_sys);
    stall <= 4'h3;
    run(8'h53, AN, IM, DD, 2'h3);
    run(8'h00, NO, RG, DA, 2'h1);
    run(8'hff, NO, RG, DA, 2'h1);
    // Known opcode after unknown ones must clear the flag
    run(8'h34, AC, IM, DA, 2'h2);
    @(posedge clk_sys);
    stall <= 4'h0;
    $display("t_slow done");
  endtask

  initial begin
    arst_n = 1'b0;
    code_valid = 1'b0;
    code_byte = 8'h00;
    stall = 4'h0;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_add();
    t_subtract_with_borrow();
    t_logic();
    t_xor();
    t_slow();
    end_sim();
  end

  // About 50 instructions of under 20 cycles each
  initial begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    end_sim();
  end
endmodule
`default_nettype wire
